// >>> common/xpt_pkg.sv
// Constants and types shared by the crosspoint switch controller
package xpt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int OUTS     = 8;
  localparam int SEL_W    = 3;
  localparam int CODE_W   = 4;
  localparam int SER_BITS = OUTS * CODE_W;
  localparam int IDX_W    = 5;
  localparam int CTRL_W   = 4;
  localparam int STAT_W   = 4;

  // ----------------------------------------------------------------
  // Register offsets of the software port
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PAR    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SER    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SERIAL_BIT = 0;
  localparam int CTRL_EDGE_BIT   = 1;
  localparam int CTRL_LOAD_BIT   = 2;
  localparam int CTRL_CHIP_BIT   = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h4;
  localparam int PAR_SEL_LSB     = 0;
  localparam int PAR_CODE_LSB    = 4;
  localparam int CMD_SHIFT_BIT   = 0;
  localparam int CMD_XFER_BIT    = 1;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_POR_BIT      = 1;
  localparam int ST_PROG_BIT     = 2;
  localparam int ST_REFUSED_BIT  = 3;

  // ----------------------------------------------------------------
  // Codes sent on the code nibble
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_LAST_CHANNEL = 4'h7;
  localparam logic [CODE_W-1:0] CODE_GROUND       = 4'h8;
  localparam logic [CODE_W-1:0] CODE_SER_ON_GND   = 4'h9;
  localparam logic [CODE_W-1:0] CODE_SER_OFF      = 4'hA;
  localparam logic [CODE_W-1:0] CODE_OFF_ONE      = 4'hB;
  localparam logic [CODE_W-1:0] CODE_ON_ONE       = 4'hC;
  localparam logic [CODE_W-1:0] CODE_OFF_ALL      = 4'hD;
  localparam logic [CODE_W-1:0] CODE_ON_ALL       = 4'hE;
  localparam logic [CODE_W-1:0] CODE_SW_XFER      = 4'hF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int POR_NS        = 5000;
  localparam int POR_CYCLES    = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W         = $clog2(POR_CYCLES + 1);

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_SETUP,
    SEQ_STROBE,
    SEQ_HOLD,
    SEQ_XFER_LOW,
    SEQ_XFER_HIGH
  } seq_state_t;

endpackage

// >>> common/timer_if.sv
// Start and done handshake between the sequencer and its phase timer
interface timer_if #(parameter int TW = 8);
  logic          start;
  logic [TW-1:0] count;
  logic          done;
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface

// >>> core/phase_timer.sv
// Down-counter that pulses done a set number of cycles after start
module phase_timer #(
  parameter int TW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  timer_if.tmr     tif
);
  import xpt_pkg::*;

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          done;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = (s_r.cnt == TW'(1));
    if (tif.start)
    begin
      s_nxt.cnt  = tif.count;
      s_nxt.done = 1'b0;
    end
    else if (s_r.cnt != '0)
    begin
      s_nxt.cnt = s_r.cnt - TW'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tif.done = s_r.done;

endmodule // phase_timer

// >>> core/xpt_host.sv
// Host controller that programs an 8 x 8 video crosspoint switch over its pins
module xpt_host #(
  parameter int SETUP_CYCLES  = 4,
  parameter int STROBE_CYCLES = 4,
  parameter int HOLD_CYCLES   = 4,
  parameter int XFER_CYCLES   = 4,
  parameter int TW            = 8
) (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [xpt_pkg::ADDR_W-1:0]   addr,
  input  wire logic [xpt_pkg::DATA_W-1:0]   wdata,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic      [xpt_pkg::DATA_W-1:0]   rdata,
  output logic      [xpt_pkg::SEL_W-1:0]    output_select,
  output logic      [xpt_pkg::CODE_W-1:0]   code_nibble,
  output logic                              write_strobe_n,
  output logic                              transfer_strobe,
  output logic                              chip_enable_n,
  output logic                              chip_enable,
  output logic                              transfer_edge_mode,
  output logic                              interface_mode_select,
  output logic                              internal_load_on
);
  import xpt_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (SETUP_CYCLES < 1 || STROBE_CYCLES < 1 || HOLD_CYCLES < 1 || XFER_CYCLES < 1)
    begin : g_bad_cycles
      $error("Phase lengths must be at least one cycle");
    end
    if (TW < 2 || SETUP_CYCLES >= (1 << TW) || STROBE_CYCLES >= (1 << TW)
        || HOLD_CYCLES >= (1 << TW) || XFER_CYCLES >= (1 << TW))
    begin : g_bad_width
      $error("Timer width too small for phase lengths");
    end
  endgenerate

  typedef struct packed {
    seq_state_t              st;
    logic [CTRL_W-1:0]       ctrl;
    logic [SER_BITS-1:0]     ser_word;
    logic [IDX_W-1:0]        bit_idx;
    logic                    ser_job;
    logic [SEL_W-1:0]        sel;
    logic [CODE_W-1:0]       code;
    logic                    wr_n;
    logic                    xfer;
    logic                    ce_n;
    logic                    ce;
    logic [POR_W-1:0]        por_cnt;
    logic                    por_done;
    logic                    programmed;
    logic                    refused;
    logic [DATA_W-1:0]       rdata;
    logic                    tstart;
    logic [TW-1:0]           tcount;
  } host_state_t;

  localparam host_state_t RESET_VAL = '{
    st: SEQ_IDLE, ctrl: CTRL_RESET, wr_n: 1'b1, xfer: 1'b1, ce_n: 1'b1, default: '0};

  host_state_t s_r;
  host_state_t s_nxt;

  timer_if #(.TW(TW)) tif ();

  phase_timer #(.TW(TW)) u_timer (
    .mclk (mclk),
    .rst  (rst),
    .tif  (tif.tmr)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Output 0 first, each code MSB first
  function automatic logic ser_bit(input logic [SER_BITS-1:0] w, input logic [IDX_W-1:0] k);
    logic [IDX_W-1:0] pos;
    pos = {k[IDX_W-1:2], ~k[1:0]};
    return w[pos];
  endfunction

  // Any code that would stall second-rank loading in serial mode
  function automatic logic has_blocking_code(input logic [SER_BITS-1:0] w);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < OUTS; i++)
    begin
      if (w[i*CODE_W +: CODE_W] >= CODE_OFF_ONE)
        bad = 1'b1;
    end
    return bad;
  endfunction

  // Codes that switch buffers on in parallel mode
  function automatic logic is_enable_code(input logic [CODE_W-1:0] c);
    return (c == CODE_ON_ONE) || (c == CODE_ON_ALL);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic             set_refused;
    logic             clr_refused;
    logic [CODE_W-1:0] wcode;
    set_refused = 1'b0;
    clr_refused = 1'b0;
    wcode       = wdata[PAR_CODE_LSB +: CODE_W];
    s_nxt        = s_r;
    s_nxt.tstart = 1'b0;
    s_nxt.rdata  = '0;

    // Wait out the device's own power-on clear
    if (!s_r.por_done)
    begin
      s_nxt.por_cnt = s_r.por_cnt + POR_W'(1);
      if (s_r.por_cnt == POR_W'(POR_CYCLES - 1))
        s_nxt.por_done = 1'b1;
    end

    // Software writes
    if (wr_en)
    begin
      unique case (addr)
        OFS_CTRL:
        begin
          if (s_r.st == SEQ_IDLE)
            s_nxt.ctrl = wdata[CTRL_W-1:0];
          else
            set_refused = 1'b1;
        end
        OFS_PAR:
        begin
          if (s_r.st != SEQ_IDLE || !s_r.por_done || s_r.ctrl[CTRL_SERIAL_BIT])
            set_refused = 1'b1;
          else if (wcode == CODE_SER_ON_GND || wcode == CODE_SER_OFF)
            set_refused = 1'b1;
          else if (is_enable_code(wcode) && !s_r.programmed)
            set_refused = 1'b1;
          else
          begin
            s_nxt.sel     = wdata[PAR_SEL_LSB +: SEL_W];
            s_nxt.code    = wcode;
            s_nxt.ser_job = 1'b0;
            s_nxt.st      = SEQ_SETUP;
            s_nxt.tstart  = 1'b1;
            s_nxt.tcount  = TW'(SETUP_CYCLES);
          end
        end
        OFS_SER:
        begin
          if (s_r.st == SEQ_IDLE)
            s_nxt.ser_word = wdata[SER_BITS-1:0];
          else
            set_refused = 1'b1;
        end
        OFS_CMD:
        begin
          if (s_r.st != SEQ_IDLE || !s_r.por_done)
            set_refused = 1'b1;
          else if (wdata[CMD_SHIFT_BIT])
          begin
            if (!s_r.ctrl[CTRL_SERIAL_BIT] || has_blocking_code(s_r.ser_word))
              set_refused = 1'b1;
            else
            begin
              s_nxt.ser_job = 1'b1;
              s_nxt.bit_idx = '0;
              s_nxt.code    = {{(CODE_W-1){1'b0}}, ser_bit(s_r.ser_word, '0)};
              s_nxt.st      = SEQ_SETUP;
              s_nxt.tstart  = 1'b1;
              s_nxt.tcount  = TW'(SETUP_CYCLES);
            end
          end
          else if (wdata[CMD_XFER_BIT])
          begin
            s_nxt.st     = SEQ_XFER_LOW;
            s_nxt.xfer   = 1'b0;
            s_nxt.tstart = 1'b1;
            s_nxt.tcount = TW'(XFER_CYCLES);
          end
        end
        OFS_STATUS:
          clr_refused = wdata[ST_REFUSED_BIT];
        default: ;
      endcase
    end

    // Strobe sequencing
    unique case (s_r.st)
      SEQ_IDLE: ;
      SEQ_SETUP:
      begin
        if (tif.done)
        begin
          s_nxt.wr_n   = 1'b0;
          s_nxt.st     = SEQ_STROBE;
          s_nxt.tstart = 1'b1;
          s_nxt.tcount = TW'(STROBE_CYCLES);
        end
      end
      SEQ_STROBE:
      begin
        if (tif.done)
        begin
          s_nxt.wr_n   = 1'b1;
          s_nxt.st     = SEQ_HOLD;
          s_nxt.tstart = 1'b1;
          s_nxt.tcount = TW'(HOLD_CYCLES);
        end
      end
      SEQ_HOLD:
      begin
        if (tif.done)
        begin
          if (s_r.ser_job && s_r.bit_idx != IDX_W'(SER_BITS - 1))
          begin
            s_nxt.bit_idx = s_r.bit_idx + IDX_W'(1);
            s_nxt.code    = {{(CODE_W-1){1'b0}},
                             ser_bit(s_r.ser_word, s_r.bit_idx + IDX_W'(1))};
            s_nxt.st      = SEQ_SETUP;
            s_nxt.tstart  = 1'b1;
            s_nxt.tcount  = TW'(SETUP_CYCLES);
          end
          else if (s_r.ser_job)
          begin
            s_nxt.xfer   = 1'b0;
            s_nxt.st     = SEQ_XFER_LOW;
            s_nxt.tstart = 1'b1;
            s_nxt.tcount = TW'(XFER_CYCLES);
          end
          else
          begin
            if (s_r.code == CODE_SW_XFER)
              s_nxt.programmed = 1'b1;
            s_nxt.st = SEQ_IDLE;
          end
        end
      end
      SEQ_XFER_LOW:
      begin
        if (tif.done)
        begin
          s_nxt.xfer   = 1'b1;
          s_nxt.st     = SEQ_XFER_HIGH;
          s_nxt.tstart = 1'b1;
          s_nxt.tcount = TW'(XFER_CYCLES);
        end
      end
      SEQ_XFER_HIGH:
      begin
        if (tif.done)
        begin
          s_nxt.programmed = 1'b1;
          s_nxt.ser_job    = 1'b0;
          s_nxt.st         = SEQ_IDLE;
        end
      end
    endcase

    // A refusal in the clearing cycle still sticks
    s_nxt.refused = (s_r.refused & ~clr_refused) | set_refused;

    // Pin levels follow control
    s_nxt.ce_n = ~s_nxt.ctrl[CTRL_CHIP_BIT];
    s_nxt.ce   = s_nxt.ctrl[CTRL_CHIP_BIT];

    // Software reads, valid in the following cycle only
    if (rd_en)
    begin
      unique case (addr)
        OFS_CTRL:   s_nxt.rdata = DATA_W'(s_r.ctrl);
        OFS_PAR:    s_nxt.rdata = DATA_W'({s_r.code, 1'b0, s_r.sel});
        OFS_SER:    s_nxt.rdata = DATA_W'(s_r.ser_word);
        OFS_STATUS: s_nxt.rdata = DATA_W'({s_r.refused, s_r.programmed, s_r.por_done,
                                            s_r.st != SEQ_IDLE});
        default:    s_nxt.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      s_r <= RESET_VAL;
    else
      s_r <= s_nxt;
  end

  assign tif.start = s_r.tstart;
  assign tif.count = s_r.tcount;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata                 = s_r.rdata;
  assign output_select         = s_r.sel;
  assign code_nibble           = s_r.code;
  assign write_strobe_n        = s_r.wr_n;
  assign transfer_strobe       = s_r.xfer;
  assign chip_enable_n         = s_r.ce_n;
  assign chip_enable           = s_r.ce;
  assign transfer_edge_mode    = s_r.ctrl[CTRL_EDGE_BIT];
  assign interface_mode_select = s_r.ctrl[CTRL_SERIAL_BIT];
  assign internal_load_on      = s_r.ctrl[CTRL_LOAD_BIT];

endmodule // xpt_host

// >>> testbench/xpt_host_props.sv
// Pin-level checks on the crosspoint host controller
module xpt_host_props #(
  parameter int STROBE_CYCLES = 4,
  parameter int XFER_CYCLES   = 4
) (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic [xpt_pkg::SEL_W-1:0]  output_select,
  input wire logic [xpt_pkg::CODE_W-1:0] code_nibble,
  input wire logic                       write_strobe_n,
  input wire logic                       transfer_strobe,
  input wire logic                       chip_enable_n,
  input wire logic                       chip_enable,
  input wire logic                       interface_mode_select
);
  timeunit 1ns;
  timeprecision 1ps;
  import xpt_pkg::*;
  // ----------------------------------------------------------------
  // Low-time counters of the two strobes
  // ----------------------------------------------------------------
  logic [7:0] wlo_r;
  logic [7:0] xlo_r;
  always_ff @(posedge mclk)
  begin
    wlo_r <= (rst || write_strobe_n) ? 8'h00 : wlo_r + 8'h01;
    xlo_r <= (rst || transfer_strobe) ? 8'h00 : xlo_r + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ce_pair; chip_enable_n == !chip_enable; endproperty
  a_ce_pair: assert property (p_ce_pair)
    else $error("chip enables disagree");
  property p_code_hold; !write_strobe_n |=> $stable(code_nibble) && $stable(output_select);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("data moved while write strobe low");
  property p_post_hold; $rose(write_strobe_n) |=> $stable(code_nibble); endproperty
  a_post_hold: assert property (p_post_hold)
    else $error("data moved right after write edge");
  property p_setup;
    $fell(write_strobe_n) |-> code_nibble == $past(code_nibble, 4)
      && output_select == $past(output_select, 4);
  endproperty
  a_setup: assert property (p_setup)
    else $error("data not set up before write strobe");
  property p_wlow; $rose(write_strobe_n) |-> wlo_r == STROBE_CYCLES + 2; endproperty
  a_wlow: assert property (p_wlow)
    else $error("write strobe low time wrong");
  property p_xlow; $rose(transfer_strobe) |-> xlo_r == XFER_CYCLES + 2; endproperty
  a_xlow: assert property (p_xlow)
    else $error("transfer strobe low time wrong");
  property p_ser_bits; interface_mode_select && !write_strobe_n |-> code_nibble[3:1] == 3'h0;
  endproperty
  a_ser_bits: assert property (p_ser_bits)
    else $error("upper data lines active in serial mode");
  property p_no_overlap; !transfer_strobe |-> write_strobe_n; endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("write and transfer strobes overlap");
  c_par: cover property ($rose(write_strobe_n) && !interface_mode_select);
  c_ser: cover property ($rose(write_strobe_n) && interface_mode_select);
  c_xfer: cover property ($rose(transfer_strobe));
endmodule // xpt_host_props

bind xpt_host xpt_host_props #(
  .STROBE_CYCLES(STROBE_CYCLES),
  .XFER_CYCLES  (XFER_CYCLES)
) u_xpt_host_props (
  .mclk(mclk), .rst(rst), .output_select(output_select), .code_nibble(code_nibble),
  .write_strobe_n(write_strobe_n), .transfer_strobe(transfer_strobe),
  .chip_enable_n(chip_enable_n), .chip_enable(chip_enable),
  .interface_mode_select(interface_mode_select)
);

// >>> testbench/xpt_dev_model.sv
// Behavioural model of the crosspoint switch control logic
module xpt_dev_model (
  input wire logic                                      rst,
  input wire logic [xpt_pkg::SEL_W-1:0]                 output_select,
  input wire logic [xpt_pkg::CODE_W-1:0]                code_nibble,
  input wire logic                                      write_strobe_n,
  input wire logic                                      transfer_strobe,
  input wire logic                                      chip_enable_n,
  input wire logic                                      chip_enable,
  input wire logic                                      transfer_edge_mode,
  input wire logic                                      interface_mode_select,
  output logic [xpt_pkg::OUTS-1:0][xpt_pkg::CODE_W-1:0] first_rank,
  // No defined value at power-up
  output logic [xpt_pkg::OUTS-1:0][xpt_pkg::CODE_W-1:0] second_rank,
  // Off buffer floats its output
  output logic [xpt_pkg::OUTS-1:0]                      buf_on,
  output int                                            wr_count
);
  timeunit 1ns;
  timeprecision 1ps;
  import xpt_pkg::*;
  // ----------------------------------------------------------------
  // Ranks and buffer enables
  // ----------------------------------------------------------------
  logic [SER_BITS-1:0] shift_q;
  task automatic load_second();
    logic blk;
    blk = 1'b0;
    for (int i = 0; i < OUTS; i++)
      if (interface_mode_select && first_rank[i] > CODE_SER_OFF) blk = 1'b1;
    for (int i = 0; i < OUTS; i++)
      if (!blk)
      begin
        second_rank[i] = (first_rank[i] == CODE_SER_ON_GND) ? CODE_GROUND : first_rank[i];
        if (first_rank[i] == CODE_SER_ON_GND) buf_on[i] = 1'b1;
        if (first_rank[i] == CODE_SER_OFF) buf_on[i] = 1'b0;
      end
  endtask
  initial
  begin
    buf_on = '0;
    wr_count = 0;
  end
  always @(posedge rst) buf_on = '0;
  always @(posedge write_strobe_n)
    if (!chip_enable_n && chip_enable)
    begin
      wr_count++;
      if (interface_mode_select)
      begin
        shift_q = {shift_q[SER_BITS-2:0], code_nibble[0]};
        for (int i = 0; i < OUTS; i++) first_rank[i] = shift_q[SER_BITS-1-4*i -: CODE_W];
      end
      else
        case (code_nibble)
          CODE_OFF_ONE: buf_on[output_select] = 1'b0;
          CODE_ON_ONE:  buf_on[output_select] = 1'b1;
          CODE_OFF_ALL: buf_on = '0;
          CODE_ON_ALL:  buf_on = '1;
          CODE_SW_XFER: if (transfer_strobe) load_second();
          default:      first_rank[output_select] = code_nibble;
        endcase
    end
  always @(posedge transfer_strobe) if (transfer_edge_mode) load_second();
  always @(negedge transfer_strobe) if (!transfer_edge_mode) load_second();
endmodule // xpt_dev_model

// >>> testbench/crosspoint_switch_control_bench.sv
// Self-checking bench of the crosspoint host controller
module crosspoint_switch_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import xpt_pkg::*;
  logic mclk, rst, wr_en, rd_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [SEL_W-1:0] output_select;
  logic [CODE_W-1:0] code_nibble;
  logic write_strobe_n, transfer_strobe, chip_enable_n, chip_enable;
  logic transfer_edge_mode, interface_mode_select, internal_load_on;
  logic [OUTS-1:0][CODE_W-1:0] first_rank, second_rank;
  logic [OUTS-1:0] buf_on;
  int wr_count;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  xpt_host u_xpt_host (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .output_select(output_select), .code_nibble(code_nibble),
    .write_strobe_n(write_strobe_n), .transfer_strobe(transfer_strobe),
    .chip_enable_n(chip_enable_n), .chip_enable(chip_enable),
    .transfer_edge_mode(transfer_edge_mode), .interface_mode_select(interface_mode_select),
    .internal_load_on(internal_load_on));
  xpt_dev_model u_xpt_dev_model (
    .rst(rst), .output_select(output_select), .code_nibble(code_nibble),
    .write_strobe_n(write_strobe_n), .transfer_strobe(transfer_strobe),
    .chip_enable_n(chip_enable_n), .chip_enable(chip_enable),
    .transfer_edge_mode(transfer_edge_mode), .interface_mode_select(interface_mode_select),
    .first_rank(first_rank), .second_rank(second_rank), .buf_on(buf_on), .wr_count(wr_count));
  // ----------------------------------------------------------------
  // Bus cycles and helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    rd(OFS_STATUS);
    while (d[b] !== v && n < 600)
    begin
      rd(OFS_STATUS);
      n++;
    end
    chk(d[b], v);
  endtask
  task automatic refused();
    rd(OFS_STATUS);
    chk(d[ST_REFUSED_BIT], 1'b1);
    wr(OFS_STATUS, 32'h0000_0008);
  endtask
  task automatic par(input logic [SEL_W-1:0] s, input logic [CODE_W-1:0] c);
    wr(OFS_PAR, {24'h000000, c, 1'b0, s});
    wait_st(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic cmd(input logic [1:0] c);
    wr(OFS_CMD, {30'h00000000, c});
    wait_st(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({write_strobe_n, transfer_strobe, chip_enable_n, chip_enable}, 4'hE);
    chk({internal_load_on, interface_mode_select}, 2'h2);
    chk(buf_on, 8'h00);
    rd(OFS_CTRL);
    chk(d, 32'h0000_0004);
    rd(8'h14);
    chk(d, 32'h0000_0000);
    par(3'h1, 4'h2);
    refused();
    chk(wr_count, 32'h0000_0000);
    wait_st(ST_POR_BIT, 1'b1);
  endtask
  task automatic t_par();
    wr(OFS_CTRL, 32'h0000_000A);
    for (int i = 0; i < OUTS; i++) par(i[2:0], i[3:0]);
    chk(first_rank, 32'h7654_3210);
    par(3'h3, CODE_ON_ONE);
    refused();
    cmd(2'h2);
    chk(second_rank, 32'h7654_3210);
    wait_st(ST_PROG_BIT, 1'b1);
    par(3'h2, CODE_GROUND);
    par(3'h0, CODE_LAST_CHANNEL);
    par(3'h0, CODE_SW_XFER);
    chk(second_rank, 32'h7654_3817);
    par(3'h0, CODE_ON_ALL);
    chk(buf_on, 8'hFF);
    par(3'h3, CODE_OFF_ONE);
    chk(buf_on, 8'hF7);
    par(3'h3, CODE_ON_ONE);
    chk(buf_on, 8'hFF);
    par(3'h0, CODE_OFF_ALL);
    chk(buf_on, 8'h00);
    rd(OFS_PAR);
    chk(d, 32'h0000_00D0);
    chk(second_rank, 32'h7654_3817);
    par(3'h1, CODE_SER_ON_GND);
    refused();
    chk({internal_load_on, transfer_edge_mode, chip_enable}, 3'h3);
  endtask
  task automatic t_chip_off();
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_PAR, 32'h0000_0051);
    wr(OFS_CTRL, 32'h0000_000A);
    refused();
    wait_st(ST_BUSY_BIT, 1'b0);
    chk(chip_enable_n, 1'b1);
    chk(first_rank, 32'h7654_3817);
  endtask
  task automatic t_serial();
    wr(OFS_CTRL, 32'h0000_000B);
    par(3'h0, 4'h1);
    refused();
    wr(OFS_SER, 32'h3971_08A9);
    rd(OFS_SER);
    chk(d, 32'h3971_08A9);
    cmd(2'h1);
    chk(first_rank, 32'h3971_08A9);
    chk(second_rank, 32'h3871_08A8);
    chk(buf_on, 8'h41);
    wr(OFS_SER, 32'h0000_00B0);
    cmd(2'h1);
    refused();
    wr(OFS_CTRL, 32'h0000_0009);
    wr(OFS_SER, 32'h0123_4567);
    cmd(2'h1);
    chk(second_rank, 32'h0123_4567);
    chk(buf_on, 8'h41);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial
  begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_par();
    t_chip_off();
    t_serial();
    print_verdict();
  end
endmodule // crosspoint_switch_control_bench
